//--- design/piv_arbiter.sv
// priority interrupt vectoring: source gathering, level arbiter, nesting, standby exit
`timescale 1ns/1ns

// Functional notes
// R1 - three levels exist; highest beats high, high beats low
// R2 - while in service, refuse requests at or below the running level
// R3 - simultaneous requests: the highest level wins
// R4 - equal levels: the smallest vector address wins
// R5 - thirty-two sources are ORed onto ten vectors
// R6 - first two vectors belong to ext_irq_a and ext_irq_b, highest or low
// R7 - other eight vectors, stride eight, may be high or low only
// R8 - halt ends on reset or any accepted interrupt
// R9 - hold ends on reset pin, chosen pin level, port 0, usb bus active
// R10 - crystal hold also ends on a base timer interrupt
// R11 - refused requests stay pending and rearbitrate after the return
module piv_arbiter
  import piv_pkg::*;
(
  // clock and reset
  input  wire logic                    sys_clk_i,
  input  wire logic                    sys_rst_i,
  // request sources, levels held by the peripherals until serviced
  input  wire logic [NUM_SRC-1:0]      src_req_i,
  input  wire logic [NUM_SRC-1:0]      src_en_i,
  // level selection per vector: 1 raises it to its upper level
  input  wire logic [NUM_VEC-1:0]      vec_lvl_up_i,
  // core handshake
  input  wire logic                    core_ack_i,
  input  wire logic                    core_reti_i,
  // standby control from the core
  input  wire logic                    halt_enter_i,
  input  wire logic                    hold_enter_i,
  input  wire logic                    xhold_enter_i,
  input  wire logic                    rst_pin_low_i,
  input  wire logic                    hold_pin_lvl_i,
  // interrupt to the core
  output logic                         irq_o,
  output logic [VEC_ADDR_W-1:0]        irq_vec_addr_o,
  output logic [1:0]                   irq_lvl_o,
  // nesting and standby state
  output logic [1:0]                   svc_lvl_o,
  output logic [NUM_VEC-1:0]           vec_pend_o,
  output logic                         stby_halt_o,
  output logic                         stby_hold_o,
  output logic                         stby_xhold_o,
  output logic                         stby_wake_o
);

  // ------------------------------------------------------------
  // source gathering
  // ------------------------------------------------------------
  logic [NUM_VEC-1:0] vec_req;
  logic [1:0]         vec_lvl [NUM_VEC];

  // any enabled source of a group raises its vector; the source stays
  // asserted until software clears it, so a refused request is held
  always_comb begin
    vec_req = '0;
    for (int s = 0; s < NUM_SRC; s++) begin
      if (src_req_i[s] && src_en_i[s]) begin
        vec_req[SRC_TO_VEC[s*VEC_IDX_W +: VEC_IDX_W]] = 1'b1; // R5
      end
    end
  end

  // per-vector level: upper level differs between the first two and the rest
  genvar v;
  generate
    for (v = 0; v < NUM_VEC; v++) begin : g_lvl
      if (v < NUM_TOP_VEC) begin : g_top
        assign vec_lvl[v] = vec_lvl_up_i[v] ? PIV_LVL_HIGHEST : PIV_LVL_LOW; // R6
      end else begin : g_grp
        assign vec_lvl[v] = vec_lvl_up_i[v] ? PIV_LVL_HIGH : PIV_LVL_LOW; // R7
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // arbitration
  // ------------------------------------------------------------
  logic                 win_vld;
  logic [VEC_IDX_W-1:0] win_idx;
  logic [1:0]           win_lvl;

  // strictly greater replaces, so the lower index is kept on a tie
  always_comb begin
    win_vld = 1'b0;
    win_idx = '0;
    win_lvl = PIV_LVL_NONE;
    for (int i = 0; i < NUM_VEC; i++) begin
      if (vec_req[i] && (vec_lvl[i] > win_lvl)) begin // R1 R3 R4
        win_vld = 1'b1;
        win_idx = VEC_IDX_W'(i);
        win_lvl = vec_lvl[i];
      end
    end
  end

  // ------------------------------------------------------------
  // in-service stack and request to the core
  // ------------------------------------------------------------
  logic [1:0]            svc_stk_r [SVC_DEPTH];
  logic [1:0]            svc_stk_nxt [SVC_DEPTH];
  logic [1:0]            svc_ptr_r;
  logic [1:0]            svc_ptr_nxt;
  logic                  irq_r;
  logic                  irq_nxt;
  logic [VEC_ADDR_W-1:0] addr_r;
  logic [VEC_ADDR_W-1:0] addr_nxt;
  logic [1:0]            lvl_r;
  logic [1:0]            lvl_nxt;
  logic [1:0]            cur_lvl;
  logic                  accept;

  // level currently running: top of stack, none when empty
  assign cur_lvl = (svc_ptr_r == 2'h0) ? PIV_LVL_NONE : svc_stk_r[svc_ptr_r - 2'h1];
  // only a strictly higher level may interrupt the routine in service
  assign accept  = win_vld && (win_lvl > cur_lvl); // R2

  always_comb begin
    svc_stk_nxt = svc_stk_r;
    svc_ptr_nxt = svc_ptr_r;
    irq_nxt     = accept; // R11
    addr_nxt    = addr_r;
    lvl_nxt     = lvl_r;
    if (accept) begin
      addr_nxt = VEC_BASE_ADDR + VEC_ADDR_W'(win_idx) * VEC_STRIDE;
      lvl_nxt  = win_lvl;
    end
    // the core takes the vector shown this cycle; push its level
    if (core_ack_i && irq_r && (svc_ptr_r < 2'(SVC_DEPTH))) begin
      svc_stk_nxt[svc_ptr_r] = lvl_r;
      svc_ptr_nxt            = svc_ptr_r + 2'h1;
      irq_nxt                = 1'b0;
    end else if (core_reti_i && (svc_ptr_r != 2'h0)) begin
      // popping lowers the bar; a held request then wins again
      svc_ptr_nxt = svc_ptr_r - 2'h1; // R11
      irq_nxt     = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int k = 0; k < SVC_DEPTH; k++) begin
        svc_stk_r[k] <= PIV_LVL_NONE;
      end
      svc_ptr_r <= 2'h0;
      irq_r     <= 1'b0;
      addr_r    <= '0;
      lvl_r     <= PIV_LVL_NONE;
    end else begin
      svc_stk_r <= svc_stk_nxt;
      svc_ptr_r <= svc_ptr_nxt;
      irq_r     <= irq_nxt;
      addr_r    <= addr_nxt;
      lvl_r     <= lvl_nxt;
    end
  end

  // ------------------------------------------------------------
  // standby modes
  // ------------------------------------------------------------
  piv_stby_t stby_r;
  piv_stby_t stby_nxt;
  logic      hold_wake;
  logic      xhold_wake;
  logic      wake;

  // hold keeps no clock, so only pin levels and latched sources wake it
  assign hold_wake  = rst_pin_low_i || hold_pin_lvl_i
                      || src_req_i[SRC_PORT0] || src_req_i[SRC_USB_ACT]; // R9
  assign xhold_wake = hold_wake || src_req_i[SRC_BASE_TMR]; // R10

  always_comb begin
    stby_nxt = stby_r;
    wake     = 1'b0;
    unique case (stby_r)
      PIV_RUN: begin
        if (xhold_enter_i) begin
          stby_nxt = PIV_XTAL_HOLD;
        end else if (hold_enter_i) begin
          stby_nxt = PIV_HOLD;
        end else if (halt_enter_i) begin
          stby_nxt = PIV_HALT;
        end
      end
      PIV_HALT: begin
        if (rst_pin_low_i || accept) begin // R8
          stby_nxt = PIV_RUN;
          wake     = 1'b1;
        end
      end
      PIV_HOLD: begin
        if (hold_wake) begin // R9
          stby_nxt = PIV_RUN;
          wake     = 1'b1;
        end
      end
      PIV_XTAL_HOLD: begin
        if (xhold_wake) begin // R10
          stby_nxt = PIV_RUN;
          wake     = 1'b1;
        end
      end
      default: begin
        stby_nxt = PIV_RUN;
      end
    endcase
  end

  logic wake_r;

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stby_r <= PIV_RUN;
      wake_r <= 1'b0;
    end else begin
      stby_r <= stby_nxt;
      wake_r <= wake;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign irq_o          = irq_r;
  assign irq_vec_addr_o = addr_r;
  assign irq_lvl_o      = lvl_r;
  assign svc_lvl_o      = cur_lvl;
  assign vec_pend_o     = vec_req;
  assign stby_halt_o    = (stby_r == PIV_HALT);
  assign stby_hold_o    = (stby_r == PIV_HOLD);
  assign stby_xhold_o   = (stby_r == PIV_XTAL_HOLD);
  assign stby_wake_o    = wake_r;

endmodule : piv_arbiter

//--- pkg/piv_pkg.sv
// shared constants and types for the priority interrupt vectoring block
package piv_pkg;

  // ------------------------------------------------------------
  // source and vector counts
  // ------------------------------------------------------------
  localparam int unsigned NUM_SRC = 32;
  localparam int unsigned NUM_VEC = 10;
  localparam int unsigned VEC_IDX_W = 4;
  localparam int unsigned VEC_ADDR_W = 20;

  // ------------------------------------------------------------
  // vector addresses: first vector plus a fixed stride
  // ------------------------------------------------------------
  localparam logic [VEC_ADDR_W-1:0] VEC_BASE_ADDR = 20'h00003;
  localparam logic [VEC_ADDR_W-1:0] VEC_STRIDE = 20'h00008;
  // number of vectors that may be raised to the highest level
  localparam int unsigned NUM_TOP_VEC = 2;

  // ------------------------------------------------------------
  // source bit positions on the request bus
  // ------------------------------------------------------------
  localparam int unsigned SRC_EXT_A = 0;    // ext_irq_a, vector 0
  localparam int unsigned SRC_EXT_B = 1;    // ext_irq_b, vector 1
  localparam int unsigned SRC_EXT_C = 2;    // vector 2
  localparam int unsigned SRC_CAP_LO = 3;   // capture_timer_low_half
  localparam int unsigned SRC_EXT_E = 4;    // ext_irq_group_e
  localparam int unsigned SRC_USB_ACT = 5;  // usb bus active
  localparam int unsigned SRC_EXT_D = 6;    // vector 3
  localparam int unsigned SRC_EXT_F = 7;    // ext_irq_group_f
  localparam int unsigned SRC_BASE_TMR = 8; // base timer
  localparam int unsigned SRC_CAP_HI = 9;   // vector 4
  localparam int unsigned SRC_EXT_G = 10;
  localparam int unsigned SRC_PWM_LO = 11;  // vector 5
  localparam int unsigned SRC_PWM_HI = 12;
  localparam int unsigned SRC_EXT_H = 13;
  localparam int unsigned SRC_SER0 = 14;    // vector 6
  localparam int unsigned SRC_USB_RST = 15;
  localparam int unsigned SRC_USB_SUSP = 16;
  localparam int unsigned SRC_UART_RX = 17;
  localparam int unsigned SRC_SER1 = 18;    // vector 7
  localparam int unsigned SRC_USB_EP = 19;
  localparam int unsigned SRC_USB_SOF = 20;
  localparam int unsigned SRC_SER4 = 21;
  localparam int unsigned SRC_UART_TX = 22;
  localparam int unsigned SRC_AUDIO = 23;   // audio_port_irq
  localparam int unsigned SRC_ADC = 24;     // vector 8
  localparam int unsigned SRC_TMR6 = 25;
  localparam int unsigned SRC_TMR7 = 26;
  localparam int unsigned SRC_PORT0 = 27;   // vector 9
  localparam int unsigned SRC_PWM0 = 28;
  localparam int unsigned SRC_PWM1 = 29;
  localparam int unsigned SRC_TMR4 = 30;
  localparam int unsigned SRC_TMR5 = 31;

  // vector index that owns each source, packed 4 bits per source
  localparam logic [NUM_SRC*VEC_IDX_W-1:0] SRC_TO_VEC = {
    4'h9, 4'h9, 4'h9, 4'h9, 4'h9, 4'h8, 4'h8, 4'h8,
    4'h7, 4'h7, 4'h7, 4'h7, 4'h7, 4'h7, 4'h6, 4'h6,
    4'h6, 4'h6, 4'h5, 4'h5, 4'h5, 4'h4, 4'h4, 4'h3,
    4'h3, 4'h3, 4'h2, 4'h2, 4'h2, 4'h2, 4'h1, 4'h0
  };

  // ------------------------------------------------------------
  // levels, encoded so that a larger code outranks a smaller one
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    PIV_LVL_NONE    = 2'h0,
    PIV_LVL_LOW     = 2'h1,
    PIV_LVL_HIGH    = 2'h2,
    PIV_LVL_HIGHEST = 2'h3
  } piv_level_t;

  // nesting depth of the in-service stack: one slot per level
  localparam int unsigned SVC_DEPTH = 3;

  // ------------------------------------------------------------
  // standby mode encoding, one-hot
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    PIV_RUN       = 4'h1,
    PIV_HALT      = 4'h2,
    PIV_HOLD      = 4'h4,
    PIV_XTAL_HOLD = 4'h8
  } piv_stby_t;

endpackage : piv_pkg

//--- verif/piv_arbiter_asserts.sv
// timing checks on arbitration, nesting and standby exit
`timescale 1ns/1ns
module piv_arbiter_chk
  import piv_pkg::*;
(
  // clock, reset, inputs and the pending vectors
  input wire logic               sys_clk_i, sys_rst_i, core_ack_i, core_reti_i,
  input wire logic               rst_pin_low_i, hold_pin_lvl_i,
  input wire logic [NUM_SRC-1:0] src_req_i,
  input wire logic [NUM_VEC-1:0] vec_lvl_up_i, vec_pend_o,
  // outputs under watch
  input wire logic               irq_o, stby_halt_o, stby_hold_o, stby_xhold_o, stby_wake_o,
  input wire logic [19:0]        irq_vec_addr_o,
  input wire logic [1:0]         irq_lvl_o, svc_lvl_o
);
  logic [1:0] bl;
  logic [3:0] bi;
  logic       hw;
  // scan downward with >= so the smallest index wins a tie
  always_comb begin
    logic [1:0] l;
    l  = 2'h0;
    bl = 2'h0;
    bi = 4'h0;
    for (int i = NUM_VEC - 1; i >= 0; i--) begin
      l = !vec_lvl_up_i[i] ? 2'h1 : (i < 2) ? 2'h3 : 2'h2;
      if (vec_pend_o[i] && l >= bl) begin
        bl = l;
        bi = 4'(i);
      end
    end
  end
  assign hw = rst_pin_low_i | hold_pin_lvl_i | src_req_i[SRC_PORT0] | src_req_i[SRC_USB_ACT];
  // ----------------------------------------------------------
  // properties
  // ----------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  a_win_addr: assert property (irq_o |-> irq_vec_addr_o ==
    VEC_BASE_ADDR + VEC_STRIDE * $past(bi)) else $error("vector address mismatch");
  a_win_lvl: assert property (irq_o |-> irq_lvl_o == $past(bl))
    else $error("level mismatch");
  a_refuse_low: assert property (irq_o |-> irq_lvl_o > svc_lvl_o)
    else $error("request not above service level");
  a_irq_rise: assert property (bl > svc_lvl_o && !irq_o && !core_reti_i
    && !stby_hold_o && !stby_xhold_o |=> irq_o) else $error("pending request not shown");
  a_ack_take: assert property (irq_o && core_ack_i |=>
    !irq_o && svc_lvl_o == $past(irq_lvl_o)) else $error("ack not taken");
  a_reti_pop: assert property (core_reti_i && !irq_o && svc_lvl_o != 2'h0
    |=> svc_lvl_o < $past(svc_lvl_o)) else $error("return did not pop");
  a_halt_exit: assert property (stby_halt_o && (rst_pin_low_i || bl > svc_lvl_o)
    |=> !stby_halt_o && stby_wake_o) else $error("halt not left");
  a_hold_exit: assert property (stby_hold_o && hw |=> !stby_hold_o)
    else $error("hold not left");
  a_xhold_exit: assert property (stby_xhold_o && (hw || src_req_i[SRC_BASE_TMR])
    |=> !stby_xhold_o) else $error("crystal hold not left");
  a_wake_pulse: assert property (stby_wake_o |=> !stby_wake_o)
    else $error("wake longer than one cycle");
  c_top: cover property (irq_o && irq_lvl_o == 2'h3);
  c_nest: cover property (irq_o && core_ack_i && svc_lvl_o != 2'h0);
  c_wake: cover property (stby_wake_o);
endmodule : piv_arbiter_chk

bind piv_arbiter piv_arbiter_chk u_chk (.*);

//--- verif/piv_core_model.sv
// processor core stand-in that takes a shown interrupt while take_en_i is high
`timescale 1ns/1ns
module piv_core_model (
  input  wire logic take_en_i,
  input  wire logic irq_i,
  output logic      ack_o
);
  // ack follows the registered request, so the taking edge sees irq high
  assign ack_o = take_en_i & irq_i;
endmodule : piv_core_model

//--- verif/tb.sv
// self-checking bench for the priority interrupt vectoring block
`timescale 1ns/1ns
module tb;
  import piv_pkg::*;
  logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, core_reti_i = 1'b0, take_en = 1'b0;
  logic halt_enter_i = 1'b0, hold_enter_i = 1'b0, xhold_enter_i = 1'b0;
  logic rst_pin_low_i = 1'b0, hold_pin_lvl_i = 1'b0, core_ack_i;
  logic [NUM_SRC-1:0] src_req_i = '0, src_en_i = '1;
  logic [NUM_VEC-1:0] vec_lvl_up_i = '0, vec_pend_o;
  logic irq_o, stby_halt_o, stby_hold_o, stby_xhold_o, stby_wake_o;
  logic [19:0] irq_vec_addr_o;
  logic [1:0] irq_lvl_o, svc_lvl_o;
  int fail_count = 0, tests_run = 0;

  piv_arbiter DUT (.*);
  piv_core_model u_core (.take_en_i(take_en), .irq_i(irq_o), .ack_o(core_ack_i));

  initial begin
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  // inputs move 1 ns after the edge so the design samples them settled
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : step
  task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk
  task automatic results;
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_arb;
    vec_lvl_up_i = 10'h008;
    src_req_i = 32'h00000045; // vec0 low, vec2 low, vec3 high
    step(1);
    chk("addr", 20'h0001b, irq_vec_addr_o);
    chk("lvl", 20'h2, irq_lvl_o);
    vec_lvl_up_i = 10'h00c;
    step(1);
    chk("addr", 20'h00013, irq_vec_addr_o);
    vec_lvl_up_i = 10'h000;
    src_req_i = 32'h00000020; // shared source on vec2
    step(1);
    chk("pend", 20'h004, vec_pend_o);
    chk("lvl", 20'h1, irq_lvl_o);
    src_req_i = '0;
    step(1);
    chk("irq", 20'h0, irq_o);
    // a masked source must not reach its vector
    src_en_i = 32'hfffffffe;
    src_req_i = 32'h00000001;
    step(1);
    chk("pend", 20'h000, vec_pend_o);
    chk("irq", 20'h0, irq_o);
    src_req_i = '0;
    src_en_i = '1;
    step(1);
    $display("arbitration test done");
  endtask : t_arb
  task automatic t_nest;
    vec_lvl_up_i = 10'h019;
    src_req_i = 32'h00000040;
    step(1);
    take_en = 1'b1;
    step(1);
    take_en = 1'b0;
    src_req_i = 32'h00000200; // same level as the one in service
    chk("svc", 20'h2, svc_lvl_o);
    step(2);
    chk("irq", 20'h0, irq_o);
    chk("pend", 20'h010, vec_pend_o);
    src_req_i = 32'h00000201;
    step(1);
    chk("addr", 20'h00003, irq_vec_addr_o);
    chk("lvl", 20'h3, irq_lvl_o);
    take_en = 1'b1;
    step(1);
    take_en = 1'b0;
    src_req_i = 32'h00000200;
    core_reti_i = 1'b1;
    chk("svc", 20'h3, svc_lvl_o);
    step(1);
    chk("svc", 20'h2, svc_lvl_o);
    step(1);
    core_reti_i = 1'b0;
    chk("svc", 20'h0, svc_lvl_o);
    step(1);
    chk("addr", 20'h00023, irq_vec_addr_o);
    src_req_i = '0;
    step(1);
    $display("nesting test done");
  endtask : t_nest
  task automatic t_halt;
    vec_lvl_up_i = '0;
    halt_enter_i = 1'b1;
    step(1);
    halt_enter_i = 1'b0;
    step(2);
    chk("halt", 20'h1, stby_halt_o);
    src_req_i = 32'h00000002;
    step(1);
    chk("halt", 20'h0, stby_halt_o);
    chk("irq", 20'h1, irq_o);
    chk("wake", 20'h1, stby_wake_o);
    src_req_i = '0;
    step(1);
    chk("wake", 20'h0, stby_wake_o);
    halt_enter_i = 1'b1;
    step(1);
    halt_enter_i = 1'b0;
    chk("halt", 20'h1, stby_halt_o);
    rst_pin_low_i = 1'b1;
    step(1);
    rst_pin_low_i = 1'b0;
    chk("halt", 20'h0, stby_halt_o);
    $display("halt test done");
  endtask : t_halt
  task automatic t_hold;
    hold_enter_i = 1'b1;
    step(1);
    hold_enter_i = 1'b0;
    src_req_i = 32'h00000100; // base timer must not end full hold
    step(2);
    chk("hold", 20'h1, stby_hold_o);
    src_req_i = 32'h08000000;
    step(1);
    chk("hold", 20'h0, stby_hold_o);
    chk("wake", 20'h1, stby_wake_o);
    src_req_i = '0;
    step(2);
    // selected pin level ends full hold
    hold_enter_i = 1'b1;
    step(1);
    hold_enter_i = 1'b0;
    chk("hold", 20'h1, stby_hold_o);
    hold_pin_lvl_i = 1'b1;
    step(1);
    hold_pin_lvl_i = 1'b0;
    chk("hold", 20'h0, stby_hold_o);
    step(1);
    // usb bus active ends full hold
    hold_enter_i = 1'b1;
    step(1);
    hold_enter_i = 1'b0;
    chk("hold", 20'h1, stby_hold_o);
    src_req_i = 32'h00000020;
    step(1);
    chk("hold", 20'h0, stby_hold_o);
    src_req_i = '0;
    step(2);
    xhold_enter_i = 1'b1;
    step(1);
    xhold_enter_i = 1'b0;
    chk("xhold", 20'h1, stby_xhold_o);
    src_req_i = 32'h00000100;
    step(1);
    chk("xhold", 20'h0, stby_xhold_o);
    src_req_i = '0;
    step(2);
    $display("hold test done");
  endtask : t_hold

  initial begin
    repeat (12) @(posedge sys_clk_i);
    #1;
    chk("rst irq", 20'h0, irq_o);
    sys_rst_i = 1'b0;
    step(1);
    t_arb();
    t_nest();
    t_halt();
    t_hold();
    results();
  end
  // hang guard
  initial begin
    #400000;
    fail_count++;
    results();
  end
endmodule : tb
